// ===== src/sensor_timing_pkg.sv
// Shared constants for the measurement sequencer: timing, register map, fields.
// Assumes a 250 MHz system clock; times are kept in tenths of a millisecond.
package sensor_timing_pkg;

  // Clock rate and the time unit used for all durations
  localparam int unsigned CLK_MHZ             = 250;
  localparam int unsigned CYCLES_PER_TENTH_MS = CLK_MHZ * 100;
  localparam int unsigned COUNT_W             = 32;

  // Longest measurement time per oversampling class, tenths of ms
  localparam int unsigned MEAS_CLASSES = 5;
  localparam int unsigned MEAS_TIME_TENTH_MS [MEAS_CLASSES] = '{64, 87, 133, 225, 432};

  // Standby time per idle interval code, tenths of ms
  localparam int unsigned IDLE_CODES = 8;
  localparam int unsigned IDLE_TIME_TENTH_MS [IDLE_CODES] =
    '{5, 625, 1250, 2500, 5000, 10000, 20000, 40000};

  // Raw result width
  localparam int unsigned RAW_W = 20;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] CONFIG_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] PRESS_OFFSET  = 8'h0C;
  localparam logic [7:0] TEMP_OFFSET   = 8'h10;

  // Field positions
  localparam int unsigned MODE_LSB      = 0;
  localparam int unsigned OSRS_T_LSB    = 2;
  localparam int unsigned OSRS_P_LSB    = 5;
  localparam int unsigned IDLE_LSB      = 5;
  localparam int unsigned STAT_MEAS_BIT = 0;
  localparam int unsigned STAT_PEND_BIT = 1;
  localparam int unsigned STAT_SHAD_BIT = 2;

  // Reset values
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [2:0] OSRS_RESET = 3'h0;
  localparam logic [2:0] IDLE_RESET = 3'h0;

  // Power mode codes
  localparam logic [1:0] MODE_SLEEP  = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h3;

  typedef enum logic [1:0] {SEQ_SLEEP, SEQ_MEASURE, SEQ_STANDBY} seq_state_type;

  // Both 01 and 10 select a single measurement
  function automatic logic isForced(input logic [1:0] m);
    return (m == 2'h1) || (m == 2'h2);
  endfunction

endpackage

// ===== src/timer_if.sv
// Interface between the sequencer and its duration timer.
// Both ends run on the same system clock.
`timescale 1ns/100ps
interface timer_if;
  import sensor_timing_pkg::*;
  logic               load;
  logic               cancel;
  logic [COUNT_W-1:0] count;
  logic               expire;
  logic               running;

  modport ctrl  (output load, output cancel, output count, input expire, input running);
  modport timer (input load, input cancel, input count, output expire, output running);
endinterface

// ===== src/duration_timer.sv
// Down-counter that times measurement and standby periods.
// Assumes load and cancel come from logic on the same clock.
`timescale 1ns/100ps
module duration_timer
  import sensor_timing_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  timer_if.timer   tm
);

  logic [COUNT_W-1:0] remaining;

  // Load wins over cancel so a restart is never lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remaining  <= '0;
      tm.running <= 1'b0;
    end else if (tm.load) begin
      remaining  <= tm.count;
      tm.running <= 1'b1;
    end else if (tm.cancel || tm.expire) begin
      remaining  <= '0;
      tm.running <= 1'b0;
    end else if (tm.running) begin
      remaining  <= remaining - 1'b1;
    end
  end

  // Expire lands exactly count cycles after the load edge
  assign tm.expire = tm.running && (remaining == {{(COUNT_W-1){1'b0}}, 1'b1});

endmodule

// ===== src/sensor_sequencer.sv
// Measurement sequencer with result shadowing and an AHB-Lite register slave.
// Assumes raw results come from a converter on clk, the chip select is a pin,
// and the I2C front end reports read start and stop on its own link clock.
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

// Contract
// - Forced time from oversampling; normal adds idle
// - Measurement lasts its oversampling class maximum
// - Normal period is measurement plus idle interval
// - Results are unsigned 20-bit values
// - Normal cycle runs regardless of host reads
// - Completion during burst goes to shadow
// - Burst end commits shadow to all data
// - Chip select rise or I2C stop ends burst
// - Mode 00 sleep, 01/10 forced, 11 normal
// - Forced does one measurement, then sleeps
// - Idle code selects one of eight standby times
// - Mode change deferred during measurement; extras ignored
module sensor_sequencer
  import sensor_timing_pkg::*;
#(
  parameter int unsigned MEAS_CYCLES [MEAS_CLASSES] = '{
    MEAS_TIME_TENTH_MS[0] * CYCLES_PER_TENTH_MS,
    MEAS_TIME_TENTH_MS[1] * CYCLES_PER_TENTH_MS,
    MEAS_TIME_TENTH_MS[2] * CYCLES_PER_TENTH_MS,
    MEAS_TIME_TENTH_MS[3] * CYCLES_PER_TENTH_MS,
    MEAS_TIME_TENTH_MS[4] * CYCLES_PER_TENTH_MS},
  parameter int unsigned IDLE_CYCLES [IDLE_CODES] = '{
    IDLE_TIME_TENTH_MS[0] * CYCLES_PER_TENTH_MS,
    IDLE_TIME_TENTH_MS[1] * CYCLES_PER_TENTH_MS,
    IDLE_TIME_TENTH_MS[2] * CYCLES_PER_TENTH_MS,
    IDLE_TIME_TENTH_MS[3] * CYCLES_PER_TENTH_MS,
    IDLE_TIME_TENTH_MS[4] * CYCLES_PER_TENTH_MS,
    IDLE_TIME_TENTH_MS[5] * CYCLES_PER_TENTH_MS,
    IDLE_TIME_TENTH_MS[6] * CYCLES_PER_TENTH_MS,
    IDLE_TIME_TENTH_MS[7] * CYCLES_PER_TENTH_MS}
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  input  wire logic [RAW_W-1:0] rawPressure,
  input  wire logic [RAW_W-1:0] rawTemperature,
  output logic                  measuring,
  input  wire logic             spiChipSelectN,
  input  wire logic             linkClk,
  input  wire logic             i2cReadStart,
  input  wire logic             i2cStop,
  output logic [RAW_W-1:0]      pressureData,
  output logic [RAW_W-1:0]      rawTemperatureValue
);

  timer_if tm ();

  // Register state
  logic [1:0]       mode;
  logic [2:0]       osrsT;
  logic [2:0]       osrsP;
  logic [2:0]       idleIntervalCode;
  logic [1:0]       pendingMode;
  logic             pendingValid;
  seq_state_type    state;

  // Bus pipeline
  logic             wrPending;
  logic [7:0]       wrAddr;
  logic [7:0]       rdAddr;
  logic             rdRefresh;
  logic             addrPhase;

  // Shadow copy of results
  logic [RAW_W-1:0] shadowPressure;
  logic [RAW_W-1:0] shadowTemperature;
  logic             shadowFull;

  // Crossing flops
  logic             csMeta;
  logic             csSync;
  logic             linkRstMeta;
  logic             linkRstN;
  logic             i2cBurst;
  logic             i2cMeta;
  logic             i2cSync;
  logic             burstPrev;
  logic             burstActive;
  logic             burstEnd;

  // Sequencer next values
  seq_state_type    next_state;
  logic [1:0]       next_mode;
  logic [1:0]       next_pendingMode;
  logic             next_pendingValid;
  logic             startMeas;
  logic             startIdle;
  logic             measDone;
  logic             stopTimer;

  // Decoded write of the control word
  logic             modeWrite;
  logic [1:0]       newMode;
  logic [2:0]       effOsrsT;
  logic [2:0]       effOsrsP;

  // Oversampling to worst-case class; unsupported combinations take the longest
  function automatic logic [2:0] measClass(input logic [2:0] t, input logic [2:0] p);
    logic [2:0] c;
    c = 3'h0;
    if ((t > 3'h2) || (p > 3'h5) || (t == 3'h2) || (p == 3'h5)) begin
      c = 3'h4;
    end else if (p > 3'h1) begin
      c = p - 3'h1;
    end
    return c;
  endfunction

  // Read decode, shared by the normal and the refresh path
  function automatic logic [31:0] readMux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      CTRL_OFFSET: begin
        d[MODE_LSB +: 2]   = mode;
        d[OSRS_T_LSB +: 3] = osrsT;
        d[OSRS_P_LSB +: 3] = osrsP;
      end
      CONFIG_OFFSET: begin
        d[IDLE_LSB +: 3] = idleIntervalCode;
      end
      STATUS_OFFSET: begin
        d[STAT_MEAS_BIT] = measuring;
        d[STAT_PEND_BIT] = pendingValid;
        d[STAT_SHAD_BIT] = shadowFull;
      end
      PRESS_OFFSET: d[RAW_W-1:0] = pressureData;
      TEMP_OFFSET:  d[RAW_W-1:0] = rawTemperatureValue;
      default:      d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // Address phase is taken only when the bus is ready
  assign addrPhase = hsel && hready && htrans[1];
  assign hresp     = 1'b0;

  // One wait state only when a read follows a write, so it sees the new value
  assign hreadyout = !rdRefresh;

  // Bus address capture; hsize is ignored as only whole words are used
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPending <= 1'b0;
      wrAddr    <= 8'h00;
      rdAddr    <= 8'h00;
      rdRefresh <= 1'b0;
    end else begin
      wrPending <= addrPhase && hwrite;
      rdRefresh <= addrPhase && !hwrite && wrPending;
      if (addrPhase) begin
        wrAddr <= haddr[7:0];
        rdAddr <= haddr[7:0];
      end
    end
  end

  // Read data is registered so it stands through the data phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rdRefresh) begin
      hrdata <= readMux(rdAddr);
    end else if (addrPhase && !hwrite) begin
      hrdata <= readMux(haddr[7:0]);
    end
  end

  // Control word fields; a mode write also carries the oversampling it runs with
  assign modeWrite = wrPending && (wrAddr == CTRL_OFFSET);
  assign newMode   = hwdata[MODE_LSB +: 2];
  assign effOsrsT  = modeWrite ? hwdata[OSRS_T_LSB +: 3] : osrsT;
  assign effOsrsP  = modeWrite ? hwdata[OSRS_P_LSB +: 3] : osrsP;

  // Oversampling and idle interval take effect at the next period start
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osrsT            <= OSRS_RESET;
      osrsP            <= OSRS_RESET;
      idleIntervalCode <= IDLE_RESET;
    end else if (wrPending) begin
      if (wrAddr == CTRL_OFFSET) begin
        osrsT <= hwdata[OSRS_T_LSB +: 3];
        osrsP <= hwdata[OSRS_P_LSB +: 3];
      end
      if (wrAddr == CONFIG_OFFSET) begin
        idleIntervalCode <= hwdata[IDLE_LSB +: 3];
      end
    end
  end

  // Mode sequencing; runs on its own, unaware of any host read
  always_comb begin
    next_state        = state;
    next_mode         = mode;
    next_pendingMode  = pendingMode;
    next_pendingValid = pendingValid;
    startMeas         = 1'b0;
    startIdle         = 1'b0;
    measDone          = 1'b0;
    stopTimer         = 1'b0;
    case (state)
      SEQ_SLEEP: begin
        if (modeWrite) begin
          next_mode = newMode;
          if (newMode != MODE_SLEEP) begin
            next_state = SEQ_MEASURE;
            startMeas  = 1'b1;
          end
        end
      end
      SEQ_MEASURE: begin
        // A write here waits; once one waits, later ones are dropped
        if (modeWrite && !pendingValid) begin
          next_pendingValid = 1'b1;
          next_pendingMode  = newMode;
        end
        if (tm.expire) begin
          measDone          = 1'b1;
          next_pendingValid = 1'b0;
          if (pendingValid) begin
            next_mode = pendingMode;
          end else if (modeWrite) begin
            next_mode = newMode;
          end else if (isForced(mode)) begin
            next_mode = MODE_SLEEP;
          end
          if (next_mode == MODE_NORMAL) begin
            next_state = SEQ_STANDBY;
            startIdle  = 1'b1;
          end else if (isForced(next_mode) && (pendingValid || modeWrite)) begin
            startMeas = 1'b1;
          end else begin
            next_mode  = MODE_SLEEP;
            next_state = SEQ_SLEEP;
          end
        end
      end
      SEQ_STANDBY: begin
        // No measurement runs in standby, so a mode write applies at once
        if (modeWrite) begin
          next_mode = newMode;
          if (newMode == MODE_SLEEP) begin
            next_state = SEQ_SLEEP;
            stopTimer  = 1'b1;
          end else if (isForced(newMode)) begin
            next_state = SEQ_MEASURE;
            startMeas  = 1'b1;
          end else if (tm.expire) begin
            next_state = SEQ_MEASURE;
            startMeas  = 1'b1;
          end
        end else if (tm.expire) begin
          next_state = SEQ_MEASURE;
          startMeas  = 1'b1;
        end
      end
      default: begin
        next_state = SEQ_SLEEP;
        next_mode  = MODE_SLEEP;
      end
    endcase
  end

  // Sequencer registers; sleep after reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state        <= SEQ_SLEEP;
      mode         <= MODE_RESET;
      pendingMode  <= MODE_RESET;
      pendingValid <= 1'b0;
    end else begin
      state        <= next_state;
      mode         <= next_mode;
      pendingMode  <= next_pendingMode;
      pendingValid <= next_pendingValid;
    end
  end

  // Forced periods use the measurement time only; normal adds the idle time
  always_comb begin
    tm.load   = startMeas || startIdle;
    tm.cancel = stopTimer;
    if (startMeas) begin
      tm.count = COUNT_W'(MEAS_CYCLES[measClass(effOsrsT, effOsrsP)]);
    end else begin
      tm.count = COUNT_W'(IDLE_CYCLES[idleIntervalCode]);
    end
  end

  duration_timer timer (
    .clk   (clk),
    .rst_n (rst_n),
    .tm    (tm)
  );

  // Converter is busy while the sequencer sits in a measurement
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      measuring <= 1'b0;
    end else begin
      measuring <= (next_state == SEQ_MEASURE);
    end
  end

  // Link reset follows the system reset; link clock may stop, so nothing
  // here depends on an edge after the stop itself
  always_ff @(posedge linkClk) begin
    linkRstMeta <= rst_n;
    linkRstN    <= linkRstMeta;
  end

  // I2C read burst is open from read start until stop; stop wins
  always_ff @(posedge linkClk) begin
    if (!linkRstN) begin
      i2cBurst <= 1'b0;
    end else if (i2cStop) begin
      i2cBurst <= 1'b0;
    end else if (i2cReadStart) begin
      i2cBurst <= 1'b1;
    end
  end

  // Chip select pin and link burst level are synchronised before use
  always_ff @(posedge clk) begin
    csMeta  <= spiChipSelectN;
    csSync  <= csMeta;
    i2cMeta <= i2cBurst;
    i2cSync <= i2cMeta;
  end

  // Burst ends on chip select rising or on the I2C stop
  assign burstActive = !csSync || i2cSync;
  assign burstEnd    = burstPrev && !burstActive;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      burstPrev <= 1'b0;
    end else begin
      burstPrev <= burstActive;
    end
  end

  // Visible results never change mid-burst; a completion in the burst-end
  // cycle is written straight through since it is newer than the shadow
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pressureData        <= '0;
      rawTemperatureValue <= '0;
      shadowPressure      <= '0;
      shadowTemperature   <= '0;
      shadowFull          <= 1'b0;
    end else if (measDone && !burstActive) begin
      pressureData        <= rawPressure;
      rawTemperatureValue <= rawTemperature;
      shadowFull          <= 1'b0;
    end else if (measDone) begin
      shadowPressure      <= rawPressure;
      shadowTemperature   <= rawTemperature;
      shadowFull          <= 1'b1;
    end else if (burstEnd && shadowFull) begin
      pressureData        <= shadowPressure;
      rawTemperatureValue <= shadowTemperature;
      shadowFull          <= 1'b0;
    end
  end

endmodule

// ===== tb/sensor_sequencer_props.sv
// Port checker for the measurement sequencer.
// Assumes a single AHB-Lite master whose hready is this slave's hreadyout.
`timescale 1ns/100ps
module sensor_sequencer_props
  import sensor_timing_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             hsel,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      hrdata,
  input wire logic             measuring,
  input wire logic             spiChipSelectN,
  input wire logic [RAW_W-1:0] pressureData,
  input wire logic [RAW_W-1:0] rawTemperatureValue
);
  // One clock domain, quiet while in reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Bus answers are always OKAY and never stall twice in a row
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("hresp not OKAY");
  property p_wait_one;
    !hreadyout |=> hreadyout;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state longer than one cycle");
  // A wait state only follows an accepted read address phase
  property p_wait_cause;
    !hreadyout |-> $past(hsel && htrans[1] && !hwrite);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait state without a read");
  // Read data stands until the next read is accepted
  property p_rdata_hold;
    hreadyout && !(hsel && htrans[1] && !hwrite) |=> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("hrdata moved without a read");
  // Sleep after reset: measuring stays low in the release cycle and the one after it
  property p_sleep_after_reset;
    $rose(rst_n) |-> !measuring ##1 !measuring;
  endproperty
  a_sleep_after_reset: assert property (p_sleep_after_reset) else $error("measuring out of reset");
  // Even the shortest class lasts far longer than eight cycles
  property p_meas_min;
    $rose(measuring) |-> measuring [*8];
  endproperty
  a_meas_min: assert property (p_meas_min) else $error("measurement cut short");
  // Six samples of chip select low cover the two-flop sync and a pending commit
  property p_shadow_hold;
    !spiChipSelectN [*6] |-> $stable(pressureData) && $stable(rawTemperatureValue);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("results changed in a burst");
  // Results move only at a measurement end or after a burst has closed
  property p_update_cause;
    $changed(pressureData) || $changed(rawTemperatureValue) |-> $past(measuring) || $past(spiChipSelectN, 2);
  endproperty
  a_update_cause: assert property (p_update_cause) else $error("results changed without cause");
endmodule

bind sensor_sequencer sensor_sequencer_props props_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .measuring(measuring),
  .spiChipSelectN(spiChipSelectN), .pressureData(pressureData), .rawTemperatureValue(rawTemperatureValue));

// ===== tb/serial_host_model.sv
// Serial-side host: brackets result reads with burst open and close.
// Assumes the link clock runs free; start and stop are one-cycle pulses on it.
`timescale 1ns/100ps
module serial_host_model (
  input  wire logic linkClk,
  output logic      spiChipSelectN,
  output logic      i2cReadStart,
  output logic      i2cStop
);
  // Idle: no burst open on either bus
  initial begin
    spiChipSelectN = 1'b1;
    i2cReadStart   = 1'b0;
    i2cStop        = 1'b0;
  end
  // All data registers are read inside one burst, so chip select spans it
  task automatic spi_burst(input logic open);
    @(posedge linkClk);
    spiChipSelectN <= !open;
  endtask
  // Start opens and stop closes an I2C burst; pulses last one link cycle
  task automatic i2c_pulse(input logic stop);
    @(posedge linkClk);
    i2cStop      <= stop;
    i2cReadStart <= !stop;
    @(posedge linkClk);
    i2cStop      <= 1'b0;
    i2cReadStart <= 1'b0;
  endtask
endmodule

// ===== tb/measurement_timing_and_result_shadowing_test.sv
// Self-checking bench for the measurement sequencer.
// Assumes shortened period parameters and the serial host model for bursts.
`timescale 1ns/100ps
module measurement_timing_and_result_shadowing_test;
  import sensor_timing_pkg::*;
  localparam int unsigned MEAS [MEAS_CLASSES] = '{40, 50, 60, 70, 80};
  localparam int unsigned IDLE [IDLE_CODES]   = '{20, 30, 40, 50, 60, 70, 80, 400};
  localparam int          LIMIT               = 30000;
  logic             clk, rst_n, linkClk, hsel, hwrite, hreadyout, hresp, measuring;
  logic             spiChipSelectN, i2cReadStart, i2cStop;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [31:0]      haddr, hwdata, hrdata;
  logic [RAW_W-1:0] rawPressure, rawTemperature, pressureData, rawTemperatureValue;
  int               err_count, check_count, cycles;

  sensor_sequencer #(.MEAS_CYCLES(MEAS), .IDLE_CYCLES(IDLE)) dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rawPressure(rawPressure),
    .rawTemperature(rawTemperature), .measuring(measuring), .spiChipSelectN(spiChipSelectN),
    .linkClk(linkClk), .i2cReadStart(i2cReadStart), .i2cStop(i2cStop), .pressureData(pressureData),
    .rawTemperatureValue(rawTemperatureValue));
  serial_host_model host_u (.linkClk(linkClk), .spiChipSelectN(spiChipSelectN), .i2cReadStart(i2cReadStart),
    .i2cStop(i2cStop));

  // 250 MHz system clock; 160 ns link clock with an unrelated phase
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #37;
    forever #80 linkClk = ~linkClk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_range(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Counts settled cycles until measuring reaches lvl; the bound stops a hang
  task automatic wait_meas(input logic lvl, output int n);
    #1;
    n = 0;
    while (measuring !== lvl && n < 2000) begin
      tick(1);
      n++;
    end
  endtask
  task automatic set_raw(input logic [RAW_W-1:0] p, input logic [RAW_W-1:0] t);
    @(posedge clk);
    rawPressure    <= p;
    rawTemperature <= t;
  endtask

  // Single AHB-Lite transfer; read data is taken at the edge ending the data phase
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] data);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, addr};
    @(posedge clk iff hreadyout);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    @(posedge clk iff hreadyout);
    data = hrdata;
  endtask
  // Write with the read address phase straight behind it, which costs one wait state
  task automatic wr_rd(input logic [7:0] addr, input logic [31:0] wdata, output logic [31:0] data);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr  <= {24'h0, addr};
    @(posedge clk iff hreadyout);
    hwrite <= 1'b0;
    hwdata <= wdata;
    @(posedge clk iff hreadyout);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    @(posedge clk iff hreadyout);
    data = hrdata;
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] unused;
    bus(1'b1, addr, data, unused);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] data;
    bus(1'b0, addr, 32'h0, data);
    check(what, exp, data);
  endtask

  // Read-only and unmapped places ignore writes; everything reads its reset value
  task automatic t_reset();
    logic [31:0] d;
    wr(STATUS_OFFSET, 32'hFFFFFFFF);
    wr(PRESS_OFFSET, 32'hFFFFFFFF);
    wr(8'h14, 32'hFFFFFFFF);
    for (int a = 0; a < 24; a += 4) rd_chk("reset value", 8'(a), 32'h0);
    wr_rd(CONFIG_OFFSET, 32'hA0, d);
    check("config read after write", 32'hA0, d);
    wr(CONFIG_OFFSET, 32'h0);
  endtask
  // One forced measurement per oversampling class, using both forced codes
  task automatic t_forced();
    int         n;
    logic [2:0] ot [6] = '{1, 1, 1, 1, 1, 2};
    logic [2:0] op [6] = '{0, 2, 3, 4, 5, 1};
    int         cls [6] = '{0, 1, 2, 3, 4, 4};
    for (int i = 0; i < 6; i++) begin
      set_raw(20'hFFFF0 + 20'(i), 20'h80001 + 20'(i));
      wr(CTRL_OFFSET, {24'h0, op[i], ot[i], (i % 2) ? 2'h2 : 2'h1});
      wait_meas(1'b1, n);
      wait_meas(1'b0, n);
      check_range("measure cycles", MEAS[cls[i]], MEAS[cls[i]], n);
      rd_chk("mode after forced", CTRL_OFFSET, {24'h0, op[i], ot[i], 2'h0});
      rd_chk("pressure", PRESS_OFFSET, {12'h0, 20'hFFFF0 + 20'(i)});
      rd_chk("temperature", TEMP_OFFSET, {12'h0, 20'h80001 + 20'(i)});
      check("single measurement", 32'h0, {31'h0, measuring});
    end
  endtask
  // Normal-mode period for every idle interval code, then back to sleep
  task automatic t_normal();
    int n, hi, lo;
    for (int c = 0; c < IDLE_CODES; c++) begin
      wr(CONFIG_OFFSET, 32'(c) << IDLE_LSB);
      wr(CTRL_OFFSET, 32'h27);
      wait_meas(1'b1, n);
      wait_meas(1'b0, hi);
      wait_meas(1'b1, lo);
      check_range("normal period", MEAS[0] + IDLE[c], MEAS[0] + IDLE[c] + 1, hi + lo);
      wr(CTRL_OFFSET, 32'h0);
      wait_meas(1'b0, n);
      tick(IDLE[c] + 2);
      check("sleep after normal", 32'h0, {31'h0, measuring});
    end
  endtask
  // Mode writes during a measurement: first one waits, the next is dropped
  task automatic t_defer();
    int n;
    wr(CTRL_OFFSET, 32'h25);
    wr(CTRL_OFFSET, 32'h27);
    rd_chk("pending change", STATUS_OFFSET, 32'h3);
    wr(CTRL_OFFSET, 32'h24);
    rd_chk("mode deferred", CTRL_OFFSET, 32'h25);
    tick(MEAS[0]);
    rd_chk("pending applied", CTRL_OFFSET, 32'h27);
    wr(CTRL_OFFSET, 32'h24);
    wait_meas(1'b0, n);
    rd_chk("sleep applied", CTRL_OFFSET, 32'h24);
  endtask
  // Two completions inside one burst; only the newest is committed at burst end
  task automatic t_shadow(input logic i2c);
    int               n;
    logic [RAW_W-1:0] a = i2c ? 20'h11111 : 20'h33333;
    wr(CONFIG_OFFSET, 32'h7 << IDLE_LSB);
    set_raw(a, ~a);
    wr(CTRL_OFFSET, 32'h27);
    wait_meas(1'b1, n);
    wait_meas(1'b0, n);
    check("normal result", {12'h0, a}, {12'h0, pressureData});
    set_raw(a + 20'h1, ~a - 20'h1);
    if (i2c) host_u.i2c_pulse(1'b0);
    else host_u.spi_burst(1'b1);
    wait_meas(1'b1, n);
    wait_meas(1'b0, n);
    set_raw(a + 20'h2, ~a - 20'h2);
    check("held pressure", {12'h0, a}, {12'h0, pressureData});
    rd_chk("shadow full", STATUS_OFFSET, 32'h4);
    wait_meas(1'b1, n);
    wait_meas(1'b0, n);
    check("held temperature", {12'h0, ~a}, {12'h0, rawTemperatureValue});
    if (i2c) host_u.i2c_pulse(1'b1);
    else host_u.spi_burst(1'b0);
    tick(160);
    check("committed pressure", {12'h0, a + 20'h2}, {12'h0, pressureData});
    check("committed temperature", {12'h0, ~a - 20'h2}, {12'h0, rawTemperatureValue});
    wr(CTRL_OFFSET, 32'h0);
    wait_meas(1'b0, n);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      final_report();
    end
  end
  // Reset long enough for both clock domains, then the scenarios in turn
  initial begin
    rst_n          = 1'b0;
    hsel           = 1'b0;
    htrans         = 2'h0;
    hwrite         = 1'b0;
    hsize          = 3'h2;
    haddr          = 32'h0;
    hwdata         = 32'h0;
    rawPressure    = 20'h0;
    rawTemperature = 20'h0;
    repeat (5) @(posedge clk);
    repeat (3) @(posedge linkClk);
    @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_forced();
    t_normal();
    t_defer();
    t_shadow(1'b0);
    t_shadow(1'b1);
    final_report();
  end
endmodule
